// ### verilog/tpfc_pkg.sv
// Constants and types of the thermal print feed controller
package tpfc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_MHZ = 50;
    localparam int DOTS = 384;
    localparam int BLOCKS = 6;
    localparam int BLOCK_DOTS = DOTS / BLOCKS;
    localparam int LINE_WORDS = DOTS / 32;
    localparam logic [1:0] STEPS_PER_LINE = 2'h2;
    localparam int STEPS_PER_MM = 16;
    localparam int LOAD_MM_S = 12;
    localparam int LOAD_RATE = LOAD_MM_S * STEPS_PER_MM;
    localparam logic [31:0] LOAD_STEP_CYC = 32'((CLK_HZ + LOAD_RATE - 1) / LOAD_RATE);
    localparam int DEF_MM_S = 56;
    localparam int DEF_RATE = DEF_MM_S * STEPS_PER_MM;
    localparam logic [31:0] RST_STEP_PER = 32'((CLK_HZ + DEF_RATE - 1) / DEF_RATE);
    localparam logic [31:0] RST_LINE_PER = 32'(2 * ((CLK_HZ + DEF_RATE - 1) / DEF_RATE));
    localparam int HEAT_US = 2530;
    localparam logic [31:0] RST_HEAT = 32'(HEAT_US * CLK_MHZ);
    localparam logic [8:0] RST_LIMIT = 9'h040;
    localparam logic [6:0] RST_DUTY = 7'h64;
    localparam logic [6:0] FULL_DUTY = 7'h64;
    localparam logic [15:0] RST_DEBOUNCE = 16'h0010;
    localparam int ON_MAX_S = 30;
    localparam logic [15:0] ON_MAX_MS = 16'(ON_MAX_S * 1000);
    localparam logic [15:0] MS_CYC = 16'(CLK_HZ / 1000);
    localparam int SHIFT_HALF_NS = 80;
    localparam int LAT_SETUP_NS = 200;
    localparam int LAT_WIDTH_NS = 100;
    localparam int STB_SETUP_NS = 300;
    localparam logic [3:0] SHIFT_HALF_CYC = 4'((SHIFT_HALF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [31:0] LAT_SETUP_CYC = 32'((LAT_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [31:0] LAT_WIDTH_CYC = 32'((LAT_WIDTH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [31:0] STB_SETUP_CYC = 32'((STB_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_IRQ_ST = 5'h02;
    localparam logic [4:0] REG_IRQ_MASK = 5'h03;
    localparam logic [4:0] REG_STEP_PER = 5'h04;
    localparam logic [4:0] REG_LINE_PER = 5'h05;
    localparam logic [4:0] REG_HEAT = 5'h06;
    localparam logic [4:0] REG_LIMIT = 5'h07;
    localparam logic [4:0] REG_DUTY = 5'h08;
    localparam logic [4:0] REG_DEBOUNCE = 5'h09;
    localparam logic [4:0] REG_FEED = 5'h0a;
    localparam logic [4:0] REG_LINE = 5'h10;
    localparam int CTRL_DYN = 0;
    localparam int CTRL_LOAD = 1;
    localparam int CTRL_GO = 2;
    localparam int IRQ_W = 4;
    localparam int IRQ_PAPER = 0;
    localparam int IRQ_REST_ON = 1;
    localparam int IRQ_REST_OFF = 2;
    localparam int IRQ_LINE = 3;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_SHIFT = 7'h02, S_LATCH = 7'h04, S_SETUP = 7'h08,
        S_HEAT = 7'h10, S_STEP = 7'h20, S_GAP = 7'h40
    } tpfc_state_type;
    typedef struct packed {
        logic [BLOCKS-1:0] strobe;
        logic data;
        logic sclk;
        logic hold_n;
    } tpfc_head_type;
    function automatic logic [3:0] step_pattern(input logic [1:0] idx);
        unique case (idx)
            2'h0: step_pattern = 4'hc;
            2'h1: step_pattern = 4'h6;
            2'h2: step_pattern = 4'h3;
            default: step_pattern = 4'h9;
        endcase
    endfunction : step_pattern
    function automatic logic [31:0] dec_sat(input logic [31:0] v, input logic [31:0] d);
        dec_sat = (v > d) ? v - d : 32'h0;
    endfunction : dec_sat
endpackage : tpfc_pkg

// ### verilog/tpfc_top.sv
// Thermal print feed controller: drives printhead and stepper, reads paper sensor
`timescale 1ns/100ps
module tpfc_top import tpfc_pkg::*; (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    input wire logic paper_sense_out_i,
    output logic dot_serial_in_o,
    output logic dot_shift_clk_o,
    output logic dot_line_hold_n_o,
    output logic heat_strobe_first_o,
    output logic heat_strobe_second_o,
    output logic heat_strobe_third_o,
    output logic heat_strobe_fourth_o,
    output logic heat_strobe_fifth_o,
    output logic heat_strobe_sixth_o,
    output logic motor_phase_a_o,
    output logic motor_phase_b_o,
    output logic motor_phase_c_o,
    output logic motor_phase_d_o
);
    tpfc_state_type state_q;
    tpfc_head_type head_q;
    logic [3:0] motor_q;
    logic [1:0] phase_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic dyn_q;
    logic load_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic irq_q;
    logic [31:0] step_per_q;
    logic [31:0] line_per_q;
    logic [31:0] heat_q;
    logic [8:0] limit_q;
    logic [6:0] duty_q;
    logic [15:0] deb_q;
    logic [DOTS-1:0] remain_q;
    logic [15:0] feed_left_q;
    logic [8:0] pos_q;
    logic [8:0] cnt_q;
    logic [2:0] blk_q;
    logic [1:0] steps_left_q;
    logic [31:0] tmr_q;
    logic [31:0] step_tmr_q;
    logic [31:0] line_tmr_q;
    logic [3:0] half_q;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic paper_out_q;
    logic [15:0] deb_cnt_q;
    logic [15:0] ms_div_q;
    logic [15:0] on_ms_q;
    logic [31:0] credit_q;
    logic rest_q;
    logic [1:0] line_steps_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Bus: one wait cycle, then the access completes
    wire logic req = avs_read_i | avs_write_i;
    wire logic wr = avs_write_i & ~wait_q;
    wire logic idle = (state_q == S_IDLE);
    wire logic go = wr && avs_address_i == REG_CTRL && avs_writedata_i[CTRL_GO] && idle;
    wire logic feed = wr && avs_address_i == REG_FEED && avs_writedata_i[15:0] != 16'h0 && idle;
    wire logic line_wr = wr && idle && avs_address_i >= REG_LINE
        && avs_address_i < REG_LINE + 5'(LINE_WORDS);
    wire logic [3:0] word_idx = 4'(avs_address_i - REG_LINE);
    wire logic [31:0] eff_per = (load_q && LOAD_STEP_CYC > step_per_q) ? LOAD_STEP_CYC
        : step_per_q;
    wire logic step_ev = (state_q == S_STEP) && !rest_q && step_tmr_q >= eff_per;
    wire logic line_ev = (state_q == S_GAP) && line_tmr_q >= line_per_q;
    wire logic ms_tick = (ms_div_q == MS_CYC - 16'h1);
    wire logic busy = !idle;
    wire logic limited = duty_q < FULL_DUTY;
    wire logic rest_on = ms_tick && !rest_q && busy && limited
        && on_ms_q == ON_MAX_MS - 16'h1;
    wire logic rest_off = ms_tick && rest_q && credit_q <= 32'(duty_q);
    wire logic paper_ev = (deb_cnt_q >= deb_q) && s3_q && !paper_out_q;
    wire logic send = remain_q[pos_q] && (!dyn_q || cnt_q < limit_q);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req && wait_q) begin
                unique case (avs_address_i)
                    REG_CTRL: rdata_q <= {30'h0, load_q, dyn_q};
                    REG_STATUS: rdata_q <= {25'h0, state_q};
                    REG_IRQ_ST: rdata_q <= {28'h0, irq_st_q};
                    REG_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
                    REG_STEP_PER: rdata_q <= step_per_q;
                    REG_LINE_PER: rdata_q <= line_per_q;
                    REG_HEAT: rdata_q <= heat_q;
                    REG_LIMIT: rdata_q <= {23'h0, limit_q};
                    REG_DUTY: rdata_q <= {25'h0, duty_q};
                    REG_DEBOUNCE: rdata_q <= {16'h0, deb_q};
                    REG_FEED: rdata_q <= {13'h0, rest_q, paper_out_q, busy, feed_left_q};
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dyn_q <= 1'b0;
            load_q <= 1'b0;
            irq_mask_q <= '0;
            step_per_q <= RST_STEP_PER;
            line_per_q <= RST_LINE_PER;
            heat_q <= RST_HEAT;
            limit_q <= RST_LIMIT;
            duty_q <= RST_DUTY;
            deb_q <= RST_DEBOUNCE;
        end else if (wr) begin
            unique case (avs_address_i)
                REG_CTRL: begin
                    dyn_q <= avs_writedata_i[CTRL_DYN];
                    load_q <= avs_writedata_i[CTRL_LOAD];
                end
                REG_IRQ_MASK: irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
                REG_STEP_PER: step_per_q <= avs_writedata_i;
                REG_LINE_PER: line_per_q <= avs_writedata_i;
                REG_HEAT: heat_q <= (avs_writedata_i == 32'h0) ? 32'h1 : avs_writedata_i;
                REG_LIMIT: limit_q <= (avs_writedata_i[8:0] == 9'h0) ? 9'h1 : avs_writedata_i[8:0];
                REG_DUTY: duty_q <= (avs_writedata_i[6:0] == 7'h0) ? 7'h1
                    : (avs_writedata_i[6:0] > FULL_DUTY) ? FULL_DUTY : avs_writedata_i[6:0];
                REG_DEBOUNCE: deb_q <= avs_writedata_i[15:0];
                default: ;
            endcase
        end
    end

    // Sticky events, set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_st_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~((wr && avs_address_i == REG_IRQ_ST)
                ? avs_writedata_i[IRQ_W-1:0] : 4'h0))
                | {line_ev, rest_off, rest_on, paper_ev};
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    // Paper sensor: three stages, then a stable count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            paper_out_q <= 1'b0;
            deb_cnt_q <= 16'h0;
        end else begin
            s1_q <= paper_sense_out_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q != s3_q || s3_q == paper_out_q) begin
                deb_cnt_q <= 16'h0;
            end else if (deb_cnt_q >= deb_q) begin
                paper_out_q <= s3_q;
                deb_cnt_q <= 16'h0;
            end else begin
                deb_cnt_q <= deb_cnt_q + 16'h1;
            end
        end
    end

    // Duty: credit grows with ON time, drains at duty rate
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ms_div_q <= 16'h0;
            on_ms_q <= 16'h0;
            credit_q <= 32'h0;
            rest_q <= 1'b0;
        end else begin
            ms_div_q <= ms_tick ? 16'h0 : ms_div_q + 16'h1;
            if (ms_tick) begin
                if (rest_q) begin
                    credit_q <= dec_sat(credit_q, 32'(duty_q));
                    if (rest_off) begin
                        rest_q <= 1'b0;
                        on_ms_q <= 16'h0;
                    end
                end else if (busy && limited) begin
                    on_ms_q <= on_ms_q + 16'h1;
                    credit_q <= credit_q + 32'(FULL_DUTY - duty_q);
                    rest_q <= rest_on;
                end else begin
                    credit_q <= dec_sat(credit_q, 32'(duty_q));
                    if (credit_q <= 32'(duty_q)) begin
                        on_ms_q <= 16'h0;
                    end
                end
            end
        end
    end

    // Motor: rotate the four states, hold between lines
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            phase_q <= 2'h0;
            motor_q <= 4'h0;
            step_tmr_q <= 32'h0;
        end else begin
            if (step_ev) begin
                phase_q <= phase_q + 2'h1;
                step_tmr_q <= 32'h0;
            end else if (step_tmr_q != 32'hffffffff) begin
                step_tmr_q <= step_tmr_q + 32'h1;
            end
            motor_q <= rest_q ? 4'h0 : step_pattern(phase_q);
        end
    end

    // Head sequencing; strobes only with paper
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= S_IDLE;
            head_q.strobe <= '0;
            head_q.data <= 1'b0;
            head_q.sclk <= 1'b0;
            head_q.hold_n <= 1'b1;
            remain_q <= '0;
            feed_left_q <= 16'h0;
            pos_q <= 9'h0;
            cnt_q <= 9'h0;
            blk_q <= 3'h0;
            steps_left_q <= 2'h0;
            tmr_q <= 32'h0;
            half_q <= 4'h0;
            line_tmr_q <= 32'h0;
        end else begin
            if (line_tmr_q != 32'hffffffff) begin
                line_tmr_q <= line_tmr_q + 32'h1;
            end
            if (state_q == S_HEAT && !paper_out_q) begin
                head_q.strobe <= dyn_q ? {BLOCKS{1'b1}} : 6'(6'h1 << blk_q);
            end else begin
                head_q.strobe <= '0;
            end
            unique case (state_q)
                S_IDLE: begin
                    if (line_wr) begin
                        remain_q[32*word_idx +: 32] <= avs_writedata_i;
                    end
                    if (go) begin
                        state_q <= S_SHIFT;
                        line_tmr_q <= 32'h0;
                        pos_q <= 9'h0;
                        cnt_q <= 9'h0;
                        half_q <= 4'h0;
                    end else if (feed) begin
                        state_q <= S_STEP;
                        feed_left_q <= avs_writedata_i[15:0];
                        steps_left_q <= STEPS_PER_LINE;
                        line_tmr_q <= 32'h0;
                    end
                end
                S_SHIFT: begin
                    if (half_q == 4'h0 && !head_q.sclk) begin
                        head_q.data <= send;
                        if (dyn_q && send) begin
                            remain_q[pos_q] <= 1'b0;
                            cnt_q <= cnt_q + 9'h1;
                        end
                    end
                    if (half_q == SHIFT_HALF_CYC - 4'h1) begin
                        half_q <= 4'h0;
                        head_q.sclk <= ~head_q.sclk;
                        if (head_q.sclk && pos_q == 9'(DOTS - 1)) begin
                            state_q <= S_LATCH;
                            tmr_q <= 32'h0;
                        end else if (head_q.sclk) begin
                            pos_q <= pos_q + 9'h1;
                        end
                    end else begin
                        half_q <= half_q + 4'h1;
                    end
                end
                S_LATCH: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q == LAT_SETUP_CYC - 32'h1) begin
                        head_q.hold_n <= 1'b0;
                    end
                    if (tmr_q == LAT_SETUP_CYC + LAT_WIDTH_CYC - 32'h1) begin
                        head_q.hold_n <= 1'b1;
                        state_q <= S_SETUP;
                        tmr_q <= 32'h0;
                    end
                end
                S_SETUP: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q == STB_SETUP_CYC - 32'h1) begin
                        state_q <= S_HEAT;
                        tmr_q <= 32'h0;
                        blk_q <= 3'h0;
                    end
                end
                S_HEAT: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q == heat_q - 32'h1) begin
                        tmr_q <= 32'h0;
                        if (dyn_q && remain_q != '0) begin
                            state_q <= S_SHIFT;
                            pos_q <= 9'h0;
                            cnt_q <= 9'h0;
                            half_q <= 4'h0;
                        end else if (!dyn_q && blk_q != 3'(BLOCKS - 1)) begin
                            blk_q <= blk_q + 3'h1;
                        end else begin
                            remain_q <= '0;
                            state_q <= S_STEP;
                            steps_left_q <= STEPS_PER_LINE;
                        end
                    end
                end
                S_STEP: begin
                    if (step_ev) begin
                        steps_left_q <= steps_left_q - 2'h1;
                        if (steps_left_q == 2'h1) begin
                            state_q <= S_GAP;
                        end
                    end
                end
                S_GAP: begin
                    if (line_ev && feed_left_q > 16'h1) begin
                        feed_left_q <= feed_left_q - 16'h1;
                        steps_left_q <= STEPS_PER_LINE;
                        line_tmr_q <= 32'h0;
                        state_q <= S_STEP;
                    end else if (line_ev) begin
                        feed_left_q <= 16'h0;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Helper: steps issued since the line began
    always_ff @(posedge clk_i) begin
        if (srst_i || (state_q == S_GAP && line_ev)) begin
            line_steps_q <= 2'h0;
        end else if (step_ev) begin
            line_steps_q <= line_steps_q + 2'h1;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign irq_o = irq_q;
    assign dot_serial_in_o = head_q.data;
    assign dot_shift_clk_o = head_q.sclk;
    assign dot_line_hold_n_o = head_q.hold_n;
    assign {heat_strobe_sixth_o, heat_strobe_fifth_o, heat_strobe_fourth_o,
        heat_strobe_third_o, heat_strobe_second_o, heat_strobe_first_o} = head_q.strobe;
    assign {motor_phase_a_o, motor_phase_b_o, motor_phase_c_o, motor_phase_d_o} = motor_q;

    sequence heat_seen_s;
        state_q == S_HEAT && !paper_out_q;
    endsequence
    two_steps_a: assert property (line_ev |-> line_steps_q == 2'h2)
        else $error("line ended without two steps");
    phase_rot_a: assert property (step_ev && !rest_q ##1 !rest_q |=>
        motor_q == step_pattern($past(phase_q, 2) + 2'h1))
        else $error("winding state out of order");
    hold_a: assert property (!srst_i && !step_ev && !rest_q ##1 !rest_q && !$rose(rest_q) |=>
        $stable(motor_q))
        else $error("winding state changed without a step");
    rest_stop_a: assert property (rest_q |-> !step_ev)
        else $error("step during rest");
    on_max_a: assert property ($rose(rest_q) |-> on_ms_q == ON_MAX_MS)
        else $error("rest not at thirty seconds");
    step_space_a: assert property (step_ev |-> step_tmr_q >= step_per_q)
        else $error("step faster than feed limit");
    load_space_a: assert property (step_ev && load_q |-> step_tmr_q >= LOAD_STEP_CYC)
        else $error("loading step too fast");
    fixed_block_a: assert property (heat_seen_s ##1 !dyn_q |-> $onehot(head_q.strobe))
        else $error("fixed mode fired several blocks");
    dyn_limit_a: assert property (dyn_q && state_q == S_SHIFT |-> cnt_q <= limit_q)
        else $error("black dot count above limit");
    line_time_a: assert property (!srst_i && $fell(state_q == S_GAP) |->
        $past(line_tmr_q) >= line_per_q)
        else $error("line shorter than line period");
    paper_off_a: assert property (paper_out_q |=> head_q.strobe == '0)
        else $error("strobe while paper out");
endmodule : tpfc_top

// ### testbench/tpfc_mech.sv
// Behavioural printhead and stepper model
`timescale 1ns/100ps
module tpfc_mech import tpfc_pkg::*; (
    input wire logic clk_i,
    input wire tpfc_head_type head_i,
    input wire logic [3:0] phase_i
);
    // Offers no head-up signal
    logic [DOTS-1:0] sreg, lat, hot, done;
    logic [DOTS-1:0] burnt = '0;
    logic [BLOCKS-1:0] ord [8];
    int acts = 0, steps = 0, bad = 0, maxon = 0, gap = 0, mingap = 99999;
    logic sc = 0;
    logic [BLOCKS-1:0] st = '0;
    logic [3:0] ph = 4'hc;
    always @(posedge clk_i) begin
        if (head_i.sclk && !sc) sreg = {head_i.data, sreg[DOTS-1:1]};
        if (!head_i.hold_n) lat = sreg;
        // Each new strobe pattern is one activation
        if (|head_i.strobe && head_i.strobe != st) begin
            for (int i = 0; i < DOTS; i++) hot[i] = lat[i] & head_i.strobe[i / BLOCK_DOTS];
            burnt |= hot;
            if ($countones(hot) > maxon) maxon = $countones(hot);
            ord[acts % 8] = head_i.strobe;
            acts++;
        end
        gap++;
        if (phase_i != ph && phase_i != 4'h0) begin
            if (phase_i != {ph[0], ph[3:1]}) bad++;
            if (gap < mingap) mingap = gap;
            if (|burnt) done = burnt;
            burnt = '0;
            gap = 0;
            steps++;
            ph = phase_i;
        end
        sc = head_i.sclk;
        st = head_i.strobe;
    end
endmodule : tpfc_mech

// ### testbench/test_thermal_print_feed_controller.sv
// Self-checking bench of the thermal print feed controller
`timescale 1ns/100ps
module test_thermal_print_feed_controller import tpfc_pkg::*; ;
    logic clk_i = 0, srst_i = 1, rd = 0, wr = 0, paper = 0;
    logic [4:0] adr = '0;
    logic [31:0] wd = '0, rdat;
    logic [DOTS-1:0] line;
    wire logic [31:0] rdo;
    wire logic wrq, irq;
    wire logic [3:0] ph;
    wire tpfc_head_type hd;
    int bad_count = 0, check_count = 0, a0, s0;
    tpfc_top dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdo), .avs_waitrequest_o(wrq),
        .irq_o(irq), .paper_sense_out_i(paper), .dot_serial_in_o(hd.data),
        .dot_shift_clk_o(hd.sclk), .dot_line_hold_n_o(hd.hold_n),
        .heat_strobe_first_o(hd.strobe[0]), .heat_strobe_second_o(hd.strobe[1]),
        .heat_strobe_third_o(hd.strobe[2]), .heat_strobe_fourth_o(hd.strobe[3]),
        .heat_strobe_fifth_o(hd.strobe[4]), .heat_strobe_sixth_o(hd.strobe[5]),
        .motor_phase_a_o(ph[3]), .motor_phase_b_o(ph[2]), .motor_phase_c_o(ph[1]),
        .motor_phase_d_o(ph[0]));
    tpfc_mech m (.clk_i(clk_i), .head_i(hd), .phase_i(ph));
    initial forever #10 clk_i = ~clk_i;
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wrq !== 1'b0);
        rdat = rdo;
        wr <= 0;
        rd <= 0;
        @(posedge clk_i);
    endtask : bus
    task automatic chk_line();
        for (int i = 0; i < LINE_WORDS; i++) chk(m.done[32*i+:32], line[32*i+:32]);
    endtask : chk_line
    // Loads the line, starts it and polls for the line-done event
    task automatic run_line(input logic [31:0] ctrl);
        for (int i = 0; i < LINE_WORDS; i++) bus(1, REG_LINE + 5'(i), line[32*i+:32]);
        a0 = m.acts;
        s0 = m.steps;
        bus(1, REG_IRQ_ST, 32'hf);
        bus(1, REG_CTRL, ctrl | 32'h4);
        do bus(0, REG_IRQ_ST, 0); while (rdat[IRQ_LINE] !== 1'b1);
    endtask : run_line
    task automatic t_fixed();
        for (int i = 0; i < LINE_WORDS; i++) line[32*i+:32] = 32'ha5c3_0000 | i;
        bus(1, REG_IRQ_MASK, 32'h8);
        run_line(0);
        repeat (2) @(posedge clk_i);
        chk(irq, 1);
        chk(m.acts - a0, BLOCKS);
        for (int k = 0; k < BLOCKS; k++) chk(m.ord[(a0 + k) % 8], 6'h1 << k);
        chk(m.steps - s0, 2);
        chk(ph, 4'h3);
        chk(m.bad, 0);
        chk(m.mingap >= 20, 1);
        chk_line();
        repeat (200) @(posedge clk_i);
        chk(ph, 4'h3);
        bus(1, REG_IRQ_ST, 32'h8);
        repeat (2) @(posedge clk_i);
        chk(irq, 0);
        $display("Fixed block test done");
    endtask : t_fixed
    task automatic t_dyn();
        line = '0;
        line[99:0] = '1;
        run_line(32'h1);
        chk(m.acts - a0, 2);
        chk(m.maxon, RST_LIMIT);
        chk(m.steps - s0, 2);
        chk_line();
        $display("Dynamic block test done");
    endtask : t_dyn
    task automatic t_paper();
        bus(1, REG_IRQ_MASK, 32'h1);
        paper <= 1;
        repeat (5) @(posedge clk_i);
        paper <= 0;
        repeat (40) @(posedge clk_i);
        chk(irq, 0);
        paper <= 1;
        do @(posedge clk_i); while (irq !== 1'b1);
        bus(0, REG_IRQ_ST, 0);
        chk(rdat[IRQ_PAPER], 1);
        bus(1, REG_IRQ_MASK, 0);
        repeat (2) @(posedge clk_i);
        chk(irq, 0);
        line = '1;
        run_line(0);
        chk(m.acts - a0, 0);
        chk(m.steps - s0, 2);
        paper <= 0;
        $display("Paper out test done");
    endtask : t_paper
    // Feeds three lines, then a capped loading feed cut by a reset
    task automatic t_feed();
        s0 = m.steps;
        bus(1, REG_FEED, 32'h3);
        do bus(0, REG_STATUS, 0); while (rdat !== 32'h1);
        chk(m.steps - s0, 6);
        chk(m.bad, 0);
        bus(1, REG_DUTY, 32'h70);
        bus(0, REG_DUTY, 0);
        chk(rdat, 32'h64);
        bus(1, REG_CTRL, 32'h2);
        s0 = m.steps;
        bus(1, REG_FEED, 32'h1);
        repeat (2000) @(posedge clk_i);
        chk(m.steps - s0, 0);
        srst_i <= 1;
        repeat (2) @(posedge clk_i);
        srst_i <= 0;
        @(posedge clk_i);
        bus(0, REG_STATUS, 0);
        chk(rdat, 32'h1);
        chk(ph, 4'hc);
        $display("Feed test done");
    endtask : t_feed
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 0;
        @(posedge clk_i);
        bus(0, REG_STATUS, 0);
        chk(rdat, 32'h1);
        chk(ph, 4'hc);
        bus(0, 5'h1f, 0);
        chk(rdat, 0);
        bus(1, REG_STEP_PER, 32'd20);
        bus(1, REG_LINE_PER, 32'd100);
        bus(1, REG_HEAT, 32'd4);
        t_fixed();
        t_dyn();
        t_paper();
        t_feed();
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        stop_test();
    end
endmodule : test_thermal_print_feed_controller
